// File: logic/delay_counter.sv
// Loadable down-counter used for each wake-up delay.
// Assumes one synchronous reset and a shared clock enable.
`timescale 1ns/1ps
module delay_counter #(
  parameter int width = 24
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             clk_en,
  // Control
  input  wire logic             start,
  input  wire logic [width-1:0] length,
  // Status
  output logic                  busy,
  output logic                  done
);

  logic [width-1:0] count_q;
  logic             busy_q;
  logic             done_q;

  wire last_count = busy_q && (count_q <= width'(1));

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_q <= '0;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
    end else if (clk_en) begin
      done_q <= 1'b0;
      if (start) begin
        count_q <= length;
        busy_q  <= (length != '0);
        done_q  <= (length == '0);
      end else if (last_count) begin
        count_q <= '0;
        busy_q  <= 1'b0;
        done_q  <= 1'b1;
      end else if (busy_q) begin
        count_q <= count_q - width'(1);
      end
    end
  end

  assign busy = busy_q;
  assign done = done_q;

endmodule

// File: logic/reset_status_and_wake_delay.sv
// Reset cause register, external reset filter and wake exit sequencer.
// Assumes cause strobes and instruction strobes are one-cycle pulses
// synchronous to sys_clk; power_on_pulse behaves as a power-on reset.
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module reset_status_and_wake_delay #(
  parameter int crystal_settle_len = reset_status_pkg::crystal_settle_cycles,
  parameter int pll_lock_len       = reset_status_pkg::pll_lock_cycles,
  parameter int cpu_prep_len       = reset_status_pkg::cpu_prep_cycles,
  parameter int internal_stable_len =
    reset_status_pkg::internal_stable_cycles,
  parameter int filter_len         = reset_status_pkg::ext_reset_filter_cycles,
  parameter int count_width        = 24
) (
  // Clock, reset, enable
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // Power-on and configuration
  input  wire logic        power_on_pulse,
  input  wire logic [1:0]  brownout_cfg_select,
  input  wire logic        ext_reset_pin_enable,
  // Reset cause events
  input  wire logic        ext_reset_pin_in,
  input  wire logic        watchdog_timeout,
  input  wire logic        brownout_reset,
  input  wire logic        reset_instr_exec,
  input  wire logic        stack_full_reset,
  input  wire logic        stack_underflow_reset,
  input  wire logic        watchdog_clear_instr,
  input  wire logic        sleep_instr,
  input  wire logic        in_power_managed,
  // Wake request
  input  wire logic        wake_event,
  input  wire logic [1:0]  wake_origin,
  input  wire logic [2:0]  wake_target,
  // Reset pin pad
  output logic             ext_reset_pin_out,
  output logic             ext_reset_pin_oe_n,
  output logic             ext_reset_pin_data,
  // Reset outputs
  output logic             device_reset,
  output logic [7:0]       last_reset_cause,
  output logic             interrupt_priority_enable,
  output logic             brownout_detect_enable,
  // Wake outputs
  output logic             cpu_clock_enable,
  output logic             primary_clock_ready,
  output logic             internal_osc_stable,
  // AXI4-Lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////
  // External reset pin filter

  logic [7:0] filt_cnt_q;
  logic       pin_reset_q;
  logic       pin_data_q;

  wire pin_low_active = ext_reset_pin_enable && !ext_reset_pin_in;
  wire filt_full      = (filt_cnt_q >= 8'(filter_len));

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      filt_cnt_q  <= 8'h00;
      pin_reset_q <= 1'b0;
      pin_data_q  <= 1'b1;
    end else if (clk_en) begin
      pin_data_q <= ext_reset_pin_enable ? 1'b1 : ext_reset_pin_in;
      if (!pin_low_active) begin
        filt_cnt_q  <= 8'h00;
        pin_reset_q <= 1'b0;
      end else if (filt_full) begin
        pin_reset_q <= 1'b1;
      end else begin
        filt_cnt_q <= filt_cnt_q + 8'h01;
      end
    end
  end

  wire pin_reset_rise = pin_low_active && filt_full && !pin_reset_q;

  ////////////////////////////////////////////////////////////////////////
  // Reset cause register

  logic       interrupt_priority_enable_q;
  logic       sw_brownout_enable_q;
  logic [4:0] flags_q;
  logic [7:0] cause_q;
  logic       dev_rst_q;

  wire sw_bor_mode = (brownout_cfg_select ==
                      reset_status_pkg::brownout_cfg_software);

  // Bus write decode (filled in below)
  logic       wr_fire;
  logic [3:0] wr_addr_q;
  logic [31:0] wr_data_q;
  logic [3:0] wr_strb_q;
  wire wr_rcs = wr_fire &&
    (wr_addr_q == reset_status_pkg::reset_control_status_addr) &&
    wr_strb_q[0];

  wire [7:0] cause_vec = {stack_underflow_reset, stack_full_reset,
                          reset_instr_exec, brownout_reset,
                          watchdog_timeout && !in_power_managed,
                          pin_reset_rise && in_power_managed,
                          pin_reset_rise && !in_power_managed,
                          power_on_pulse};

  // Flag next values: hardware event wins over software write
  logic [4:0] flags_d;
  always_comb begin
    flags_d = flags_q;
    if (wr_rcs)
      flags_d = (flags_q & ~reset_status_pkg::sw_flag_mask) |
                (wr_data_q[4:0] & reset_status_pkg::sw_flag_mask);
    if (watchdog_clear_instr)
      flags_d[reset_status_pkg::sleep_entered_flag_bit] = 1'b1;
    if (sleep_instr)
      flags_d[reset_status_pkg::sleep_entered_flag_bit] = 1'b0;
    if (watchdog_clear_instr || sleep_instr)
      flags_d[reset_status_pkg::watchdog_expired_flag_bit] = 1'b1;
    if (watchdog_timeout)
      flags_d[reset_status_pkg::watchdog_expired_flag_bit] = 1'b0;
    if (reset_instr_exec)
      flags_d[reset_status_pkg::reset_instr_flag_bit] = 1'b0;
    if (brownout_reset)
      flags_d[reset_status_pkg::brownout_flag_bit] = 1'b0;
    if (power_on_pulse)
      flags_d = 5'h1c;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      interrupt_priority_enable_q    <= 1'b0;
      sw_brownout_enable_q  <= 1'b1;
      flags_q   <= 5'h1c;
      cause_q   <= 8'h01;
      dev_rst_q <= 1'b0;
    end else if (clk_en) begin
      flags_q   <= flags_d;
      dev_rst_q <= |cause_vec;
      if (|cause_vec)
        cause_q <= cause_vec;
      if (power_on_pulse)
        interrupt_priority_enable_q <= 1'b0;
      else if (wr_rcs)
        interrupt_priority_enable_q <= wr_data_q[reset_status_pkg::interrupt_priority_enable_bit];
      if (power_on_pulse)
        sw_brownout_enable_q <= 1'b1;
      else if (wr_rcs && sw_bor_mode)
        sw_brownout_enable_q <= wr_data_q[reset_status_pkg::sw_brownout_enable_bit];
    end
  end

  // read zero outside config 01; bit five zero
  wire [7:0] rcs_view = {interrupt_priority_enable_q, sw_brownout_enable_q && sw_bor_mode, 1'b0, flags_q};
  // software control only under config 01
  wire bor_en = sw_bor_mode ? sw_brownout_enable_q : (brownout_cfg_select != 2'h0);

  ////////////////////////////////////////////////////////////////////////
  // Wake exit sequencer

  typedef enum {wake_idle, wake_settle, wake_lock, wake_wait} wake_type;
  wake_type state_q;
  logic     cpu_en_q;
  logic     pri_ready_q;
  logic     int_stable_q;
  logic     prep_wait_q;

  wire tgt_crystal = (wake_target ==
                      reset_status_pkg::src_crystal_mode) ||
                     (wake_target ==
                      reset_status_pkg::src_high_speed_crystal_mode);
  wire tgt_pll = (wake_target == reset_status_pkg::src_crystal_pll_mode) ||
                 (wake_target ==
                  reset_status_pkg::src_high_speed_crystal_pll_mode);
  wire tgt_int = (wake_target == reset_status_pkg::src_internal_osc_block);
  wire from_pri = (wake_origin == reset_status_pkg::from_primary_clock_idle);
  wire from_int = (wake_origin == reset_status_pkg::from_internal_osc_block);

  // crystal timer only for crystal targets, not primary idle
  wire need_settle = !from_pri && (tgt_crystal || tgt_pll);
  // no delay at all for these
  wire no_delay    = from_pri || (from_int && tgt_int);
  wire need_stable = tgt_int && !from_int && !from_pri;

  wire start_wake  = clk_en && wake_event && (state_q == wake_idle);
  wire prep_done;
  wire settle_done;
  wire lock_done;
  wire stable_done;

  // preparation delay started with the settle and stable delays
  delay_counter #(.width(count_width)) u_prep (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .start   (start_wake && !no_delay),
    .length  (count_width'(cpu_prep_len)),
    .busy    (),
    .done    (prep_done)
  );

  delay_counter #(.width(count_width)) u_settle (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .start   (start_wake && need_settle),
    .length  (count_width'(crystal_settle_len)),
    .busy    (),
    .done    (settle_done)
  );

  delay_counter #(.width(count_width)) u_lock (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .start   (settle_done && tgt_pll),
    .length  (count_width'(pll_lock_len)),
    .busy    (),
    .done    (lock_done)
  );

  delay_counter #(.width(count_width)) u_stable (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .start   (start_wake && need_stable),
    .length  (count_width'(internal_stable_len)),
    .busy    (),
    .done    (stable_done)
  );

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q      <= wake_idle;
      cpu_en_q     <= 1'b1;
      pri_ready_q  <= 1'b1;
      int_stable_q <= 1'b0;
      prep_wait_q  <= 1'b0;
    end else if (clk_en) begin
      if (stable_done)
        int_stable_q <= 1'b1;
      // Preparation may end while a longer delay still runs
      if (prep_done)
        prep_wait_q <= 1'b0;
      case (state_q)
        wake_idle: begin
          if (wake_event) begin
            cpu_en_q    <= no_delay;
            prep_wait_q <= !no_delay;
            if (need_settle)
              pri_ready_q <= 1'b0;
            if (need_stable)
              int_stable_q <= 1'b0;
            if (!no_delay)
              state_q <= need_settle ? wake_settle : wake_wait;
          end
        end
        wake_settle: begin
          if (settle_done)
            state_q <= tgt_pll ? wake_lock : wake_wait;
        end
        wake_lock: begin
          if (lock_done)
            state_q <= wake_wait;
        end
        wake_wait: begin
          if (prep_done || !prep_wait_q) begin
            cpu_en_q    <= 1'b1;
            pri_ready_q <= pri_ready_q || tgt_crystal || tgt_pll;
            state_q     <= wake_idle;
          end
        end
        default: state_q <= wake_idle;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  logic        aw_q, w_q, bvalid_q, rvalid_q, arready_q;
  logic [31:0] rdata_q;
  logic [1:0]  bresp_q, rresp_q;

  assign wr_fire = aw_q && w_q && !bvalid_q;
  wire wr_known = (wr_addr_q == reset_status_pkg::reset_control_status_addr);
  wire [31:0] rd_mux =
    (s_axi_araddr == reset_status_pkg::reset_control_status_addr) ?
      {24'h000000, rcs_view} :
    (s_axi_araddr == reset_status_pkg::wake_status_addr) ?
      {29'h0, int_stable_q, pri_ready_q, cpu_en_q} :
      32'h00000000;
  wire rd_known =
    (s_axi_araddr == reset_status_pkg::reset_control_status_addr) ||
    (s_axi_araddr == reset_status_pkg::wake_status_addr);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aw_q      <= 1'b0;
      w_q       <= 1'b0;
      wr_addr_q <= 4'h0;
      wr_data_q <= 32'h00000000;
      wr_strb_q <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= reset_status_pkg::resp_okay;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= reset_status_pkg::resp_okay;
    end else if (clk_en) begin
      if (s_axi_awvalid && !aw_q) begin
        aw_q      <= 1'b1;
        wr_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q) begin
        w_q       <= 1'b1;
        wr_data_q <= s_axi_wdata;
        wr_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_known ? reset_status_pkg::resp_okay :
                               reset_status_pkg::resp_slverr;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        aw_q     <= 1'b0;
        w_q      <= 1'b0;
      end
      arready_q <= s_axi_arvalid && !arready_q && !rvalid_q;
      if (arready_q) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_mux;
        rresp_q  <= rd_known ? reset_status_pkg::resp_okay :
                               reset_status_pkg::resp_slverr;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  logic awready_q, wready_q, bor_en_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bor_en_q  <= 1'b0;
    end else if (clk_en) begin
      awready_q <= s_axi_awvalid && !aw_q && !awready_q;
      wready_q  <= s_axi_wvalid && !w_q && !wready_q;
      bor_en_q  <= bor_en;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  assign ext_reset_pin_out  = 1'b0;
  assign ext_reset_pin_oe_n = 1'b1;
  assign ext_reset_pin_data = pin_data_q;

  assign device_reset              = dev_rst_q;
  assign last_reset_cause          = cause_q;
  assign interrupt_priority_enable = interrupt_priority_enable_q;
  assign cpu_clock_enable          = cpu_en_q;
  assign primary_clock_ready       = pri_ready_q;
  assign internal_osc_stable       = int_stable_q;

  assign brownout_detect_enable = bor_en_q;

endmodule

// File: logic/reset_status_pkg.sv
// Constants for the reset status and wake delay block.
// Assumes a 100 MHz sys_clk and an AXI4-Lite register bus.
package reset_status_pkg;

  // Register map (byte addresses)
  localparam logic [3:0] reset_control_status_addr = 4'h0;
  localparam logic [3:0] wake_control_addr         = 4'h4;
  localparam logic [3:0] wake_status_addr          = 4'h8;

  // Field positions of reset_control_status
  localparam int interrupt_priority_enable_bit = 7;
  localparam int sw_brownout_enable_bit        = 6;
  localparam int reset_instr_flag_bit          = 4;
  localparam int watchdog_expired_flag_bit     = 3;
  localparam int sleep_entered_flag_bit        = 2;
  localparam int power_up_flag_bit             = 1;
  localparam int brownout_flag_bit             = 0;

  // Reset-cause flags: the low five bits
  localparam int cause_flag_count = 5;

  // Cause flags that software may set back
  localparam logic [4:0] sw_flag_mask = 5'h13;

  // Brown-out configuration that hands control to software
  localparam logic [1:0] brownout_cfg_software = 2'h1;

  // Bus responses
  localparam logic [1:0] resp_okay   = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  // Timing
  localparam int  clock_mhz              = 100;
  localparam int  crystal_settle_cycles  = 1024;
  localparam int  pll_lock_time_us       = 2000;
  localparam int  pll_lock_cycles        = pll_lock_time_us * clock_mhz;
  localparam int  cpu_prep_time_ns       = 100;
  localparam int  cpu_prep_cycles        =
    (cpu_prep_time_ns * clock_mhz + 999) / 1000;
  localparam int  internal_stable_time_us = 1;
  localparam int  internal_stable_cycles  =
    internal_stable_time_us * clock_mhz;
  localparam int  ext_reset_filter_cycles = 4;

  // Clock sources before and after wake-up
  typedef enum logic [2:0] {
    src_crystal_mode,
    src_high_speed_crystal_mode,
    src_crystal_pll_mode,
    src_high_speed_crystal_pll_mode,
    src_external_clock_mode,
    src_internal_osc_block
  } clock_source_type;

  typedef enum logic [1:0] {
    from_primary_clock_idle,
    from_secondary_or_low_freq,
    from_internal_osc_block,
    from_sleep
  } wake_origin_type;

endpackage

// File: verif/reset_sources_model.sv
// Far side: instruction and fault strobes plus the reset pin.
// Assumes the bench raises fire for one clock at a time.
`timescale 1ns/1ps
module reset_sources_model (
  // Requests from the bench
  input  wire logic       fire,
  input  wire logic [2:0] code,
  input  wire logic       hold_low,
  // Toward the block
  output logic            ext_reset_pin_in,
  output logic            watchdog_timeout,
  output logic            brownout_reset,
  output logic            reset_instr_exec,
  output logic            stack_full_reset,
  output logic            stack_underflow_reset,
  output logic            watchdog_clear_instr,
  output logic            sleep_instr
);
  assign ext_reset_pin_in = !hold_low;
  assign watchdog_timeout = fire && code == 3'h0;
  assign brownout_reset = fire && code == 3'h1;
  assign reset_instr_exec = fire && code == 3'h2;
  assign stack_full_reset = fire && code == 3'h3;
  assign stack_underflow_reset = fire && code == 3'h4;
  assign watchdog_clear_instr = fire && code == 3'h5;
  assign sleep_instr = fire && code == 3'h6;
endmodule

// File: verif/reset_status_assertions.sv
// Port-level checks for the reset status and wake delay block.
// Assumes it is bound to the top module; one clock, sync reset.
`timescale 1ns/1ps
module reset_status_assertions #(
  parameter int filter_len = 4
) (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       clk_en,
  // Reset pin
  input wire logic       ext_reset_pin_in,
  input wire logic       ext_reset_pin_enable,
  input wire logic       ext_reset_pin_out,
  input wire logic       ext_reset_pin_oe_n,
  input wire logic       ext_reset_pin_data,
  // Reset causes
  input wire logic       watchdog_timeout,
  input wire logic       brownout_reset,
  input wire logic       reset_instr_exec,
  input wire logic       stack_full_reset,
  input wire logic       stack_underflow_reset,
  input wire logic       in_power_managed,
  input wire logic       device_reset,
  input wire logic [7:0] last_reset_cause,
  // Wake
  input wire logic       wake_event,
  input wire logic [1:0] wake_origin,
  input wire logic [2:0] wake_target,
  input wire logic       cpu_clock_enable
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  //////////////////////////////////////////
  // Counts enabled low samples of the pin
  logic [3:0] low_q;
  always_ff @(posedge sys_clk) begin
    if (rst || ext_reset_pin_in || !ext_reset_pin_enable) begin
      low_q <= 4'h0;
    end else if (low_q != 4'hf) begin
      low_q <= low_q + 4'h1;
    end
  end
  //////////////////////////////////////////
  AST_PIN_NEVER_DRIVEN: assert property (
    ext_reset_pin_oe_n && !ext_reset_pin_out) else $error("pin driven");
  AST_PIN_FILTER_RESET: assert property (
    low_q == filter_len + 1 |-> ##[0:4] device_reset)
    else $error("held pin gave no reset");
  AST_PIN_GLITCH: assert property (
    $rose(ext_reset_pin_in) && low_q != 4'h0 && low_q < filter_len
    |-> (!device_reset) [*4]) else $error("glitch reset");
  AST_PIN_DISABLED_DATA: assert property (
    (!ext_reset_pin_enable && $stable(ext_reset_pin_in)) [*4]
    |-> ext_reset_pin_data == ext_reset_pin_in) else $error("pin data");
  AST_PIN_DISABLED_QUIET: assert property (
    (!ext_reset_pin_enable) [*6] |-> !(device_reset &&
    last_reset_cause[2:1] != 2'h0)) else $error("disabled pin reset");
  AST_EVENT_RESETS: assert property (
    clk_en && (watchdog_timeout && !in_power_managed || brownout_reset
    || reset_instr_exec || stack_full_reset || stack_underflow_reset)
    |=> device_reset) else $error("event without reset");
  AST_WDT_CAUSE: assert property (
    clk_en && watchdog_timeout && !in_power_managed
    |-> ##[1:2] last_reset_cause == 8'h08) else $error("watchdog cause");
  AST_UNDERFLOW_CAUSE: assert property (
    clk_en && stack_underflow_reset
    |-> ##[1:2] last_reset_cause == 8'h80) else $error("underflow cause");
  AST_PREP_HOLD: assert property (
    $fell(cpu_clock_enable) |-> (!cpu_clock_enable) [*8])
    else $error("exit delay short");
  AST_EXT_CLOCK_WAKE: assert property (
    wake_event && cpu_clock_enable && wake_target == 3'h4
    && wake_origin != 2'h0 |=> !cpu_clock_enable ##[6:14] cpu_clock_enable)
    else $error("external clock wake");
  cover property (wake_event && wake_target == 3'h2);
  cover property (low_q == filter_len + 1);
  cover property ($rose(cpu_clock_enable));
endmodule

bind reset_status_and_wake_delay reset_status_assertions #(
  .filter_len(filter_len)) u_reset_status_assertions (.*);

// File: verif/testbench.sv
// Self-checking bench for the reset status and wake delay block.
// Assumes package, design, checker and source model compile first.
`timescale 1ns/1ps
module testbench;
  localparam int pll_lock_len = 20;
  localparam int stab = 50;
  localparam int prep = reset_status_pkg::cpu_prep_cycles;
  localparam int settle = reset_status_pkg::crystal_settle_cycles;
  localparam logic [1:0] ok = reset_status_pkg::resp_okay;
  logic sys_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, power_on_pulse = 1'b0;
  logic [1:0] brownout_cfg_select = 2'h1, wake_origin = 2'h0;
  logic ext_reset_pin_enable = 1'b1, in_power_managed = 1'b0;
  logic wake_event = 1'b0, fire = 1'b0, hold_low = 1'b0;
  logic [2:0] wake_target = 3'h0, code = 3'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic ext_reset_pin_in, watchdog_timeout, brownout_reset, reset_instr_exec;
  logic stack_full_reset, stack_underflow_reset, watchdog_clear_instr;
  logic sleep_instr, ext_reset_pin_out, ext_reset_pin_oe_n, device_reset;
  logic ext_reset_pin_data, interrupt_priority_enable, cpu_clock_enable;
  logic brownout_detect_enable, primary_clock_ready, internal_osc_stable;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [7:0] last_reset_cause, m;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int n_errors = 0, checked = 0, cycles = 0;

  reset_status_and_wake_delay #(
    .pll_lock_len(pll_lock_len), .internal_stable_len(stab)
  ) u_reset_status_and_wake_delay (.*);
  reset_sources_model u_reset_sources_model (.*);

  always #5 sys_clk = ~sys_clk;
  //////////////////////////////////////////
  function automatic logic [31:0] view(input logic [7:0] v);
    return {24'h0, v[7], v[6] && brownout_cfg_select ==
            reset_status_pkg::brownout_cfg_software, 1'b0, v[4:0]};
  endfunction
  function automatic logic [7:0] after(input logic [7:0] v, input int c);
    case (c)
      0: v[3] = 1'b0;
      1: v[0] = 1'b0;
      2: v[4] = 1'b0;
      5: v[3:2] = 2'b11;
      6: v[3:2] = 2'b10;
      default: ;
    endcase
    return v;
  endfunction
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e, input string s);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, s, g, e);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  //////////////////////////////////////////
  // Bus master: hold each channel until its own ready
  task automatic wr(input logic [3:0] a, input logic [7:0] v,
                    output logic [1:0] rs);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wrm(input logic [7:0] v);
    logic [1:0] rs;
    wr(4'h0, v, rs);
    chk(rs, ok, "bresp");
    m = {v[7:6], 1'b0, v[4], m[3:2], v[1:0]};
  endtask
  task automatic rchk(input logic [31:0] k);
    logic [31:0] v;
    logic [1:0] rs;
    rd(4'h0, v, rs);
    chk(rs, ok, "rresp");
    chk(v & k, view(m) & k, "status");
  endtask
  task automatic wake_run(input logic [1:0] o, input logic [2:0] t);
    int n, lo, hi;
    n = 0;
    lo = (o == 2'h0 || (o == 2'h2 && t == 3'h5)) ? 0 : prep;
    if (o != 2'h0 && t < 3'h4) lo = settle + (t > 3'h1 ? pll_lock_len : 0);
    hi = lo == 0 ? 0 : lo + 6;
    wake_origin <= o;
    wake_target <= t;
    wake_event <= 1'b1;
    @(posedge sys_clk);
    wake_event <= 1'b0;
    repeat (hi + 8) begin
      @(posedge sys_clk);
      if (cpu_clock_enable !== 1'b1) n++;
    end
    chk(n >= lo && n <= hi, 1, "exit delay");
    if (o == 2'h1 && t == 3'h5) chk(internal_osc_stable, 0, "early");
    cyc(stab);
    chk(t == 3'h5 ? internal_osc_stable : primary_clock_ready, 1, "rdy");
  endtask
  //////////////////////////////////////////
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(32'h6169af0b));
    cyc(20);
    rst <= 1'b0;
    @(posedge sys_clk);
    power_on_pulse <= 1'b1;
    @(posedge sys_clk);
    power_on_pulse <= 1'b0;
    cyc(3);
    m = 8'h5c;
    rchk(32'hff);
    chk({ext_reset_pin_oe_n, ext_reset_pin_out}, 2'b10, "pad");
    for (int i = 0; i < 6; i++) begin
      wrm(i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'($urandom));
      rchk(32'hff);
      chk(interrupt_priority_enable, m[7], "interrupt_priority_enable");
      chk(brownout_detect_enable, m[6], "sw_brownout_enable");
    end
    brownout_cfg_select <= 2'h2;
    cyc(2);
    rchk(32'hff);
    chk(brownout_detect_enable, 1, "hw bor");
    brownout_cfg_select <= 2'h1;
    for (int c = 0; c < 7; c++) begin
      wrm(8'hd3);
      code <= c[2:0];
      fire <= 1'b1;
      @(posedge sys_clk);
      fire <= 1'b0;
      cyc(4);
      if (c < 5) chk(last_reset_cause, 8'h08 << c, "cause");
      m = after(m, c);
      rchk(32'h1f);
    end
    for (int p = 0; p < 2; p++) begin
      in_power_managed <= p[0];
      hold_low <= 1'b1;
      cyc(10);
      hold_low <= 1'b0;
      cyc(4);
      chk(last_reset_cause, p == 0 ? 8'h02 : 8'h04, "pin");
    end
    hold_low <= 1'b1;
    in_power_managed <= 1'b0;
    cyc(2);
    hold_low <= 1'b0;
    cyc(8);
    chk(last_reset_cause, 8'h04, "glitch");
    ext_reset_pin_enable <= 1'b0;
    hold_low <= 1'b1;
    cyc(10);
    chk(ext_reset_pin_data, 0, "data low");
    chk(last_reset_cause, 8'h04, "no pin reset");
    hold_low <= 1'b0;
    cyc(4);
    chk(ext_reset_pin_data, 1, "data high");
    ext_reset_pin_enable <= 1'b1;
    wr(4'h4, 8'hff, r);
    chk(r, reset_status_pkg::resp_slverr, "reserved");
    rd(4'hc, d, r);
    chk(r, reset_status_pkg::resp_slverr, "unmapped");
    wake_run(2'h3, 3'h4);
    wake_run(2'h3, 3'h0);
    wake_run(2'h1, 3'h2);
    wake_run(2'h1, 3'h5);
    wake_run(2'h2, 3'h5);
    wake_run(2'h0, 3'h0);
    wake_run(2'h2, 3'h1);
    wake_run(2'h3, 3'h3);
    report_and_stop();
  end
endmodule
